/* verilog/spi_cmd_regs.vh */
`ifndef SPI_CMD_REGS_VH
`define SPI_CMD_REGS_VH

// frame layout, both directions
`define FRAME_BITS 16
`define FRAME_MSB 15
`define WR_BIT 15
`define PARITY_BIT 15
`define ADDR_MSB 14
`define ADDR_LSB 12
`define DATA_MSB 11
`define DATA_LSB 0
`define BYTE_BITS_MASK 3'h7

// register addresses
`define ADDR_DIAG 3'h0
`define ADDR_CFG0 3'h1
`define ADDR_CFG1 3'h2
`define ADDR_CFG2 3'h3
`define ADDR_CFG3 3'h4
`define ADDR_CMD 3'h7

// command encodings at the command address
`define SHORT_DIAG_STATUS_CMD 12'h3C5
`define STATUS_FEEDBACK_CMD 12'h3CA

// reset values
`define CFG_RESET 12'h000
`define RESP_ADDR_RESET 3'h7

// response source selector
`define RESP_REG 2'h0
`define RESP_SDIAG 2'h1
`define RESP_FEEDBACK 2'h2

// core clock: stands in for the internal oscillator
`define OSC_FREQ_KHZ 500
`define CORE_FREQ_KHZ 100000

`endif

/* verilog/sync_two_ff.v */
`timescale 1ns/100ps
module sync_two_ff #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // level in and out
  input wire i_async,
  output reg o_sync
);

  reg stage1;

  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stage1 <= RESET_VAL;
      o_sync <= RESET_VAL;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

/* verilog/response_word.v */
`timescale 1ns/100ps
`include "spi_cmd_regs.vh"
module response_word (
  // fields
  input wire [2:0] i_addr,
  input wire [11:0] i_data,
  // assembled frame
  output wire [15:0] o_word
);

  wire response_parity;

  // odd count of ones over address and data gives 1
  assign response_parity = ^{i_addr, i_data}; // R17
  assign o_word = {response_parity, i_addr, i_data}; // R16

endmodule

/* verilog/spi_slave_command_port.v */
// Functional notes
// R01: transfers only accepted while chip select is low; else clock, input ignored.
// R02: serial output high impedance while chip select is high.
// R03: falling chip select loads the response word into the shift register.
// R04: rising chip select decodes only on a nonzero multiple of eight clocks.
// R05: input sampled on falling serial clock, output changes on rising edge.
// R06: master keeps serial clock low whenever chip select changes.
// R07: both directions shift most significant bit first.
// R08: first output bit at chip select fall, next ones after rising clocks.
// R09: acts as a sixteen bit stage in a daisy chain.
// R10: master shifts N times sixteen bits for N chained devices.
// R11: input frame: write flag bit 15, address 14:12, data 11:0.
// R12: write updates the register only at the frame-ending chip select rise.
// R13: after a write the next frame returns the written register.
// R14: read returns the register contents in the following frame.
// R15: read takes two frames; second frame may carry a new command.
// R16: output frame: parity bit 15, address 14:12, data 11:0.
// R17: parity is 1 for odd ones in address and data, else 0.
// R18: first response after reset is the short diagnosis status word.
// R19: internal logic runs from the core oscillator clock.
// R20: discarded short frames set a readable communication error.
// R21: registers return to defaults on reset only.
// R22: unknown command patterns are ignored and flag a communication error.
`timescale 1ns/100ps
`include "spi_cmd_regs.vh"
module spi_slave_command_port (
  // core clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // serial link
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_si,
  output reg o_so,
  output reg o_so_oe,
  // device state seen by software
  input wire [11:0] i_diag,
  // configuration registers
  output reg [11:0] o_cfg0,
  output reg [11:0] o_cfg1,
  output reg [11:0] o_cfg2,
  output reg [11:0] o_cfg3,
  // error indication
  output reg o_comm_err
);

  // synchronised pins
  wire cs_n_s;
  wire sclk_s;
  wire si_s;
  reg cs_n_d;
  reg sclk_d;

  // edge events
  wire cs_fall;
  wire cs_rise;
  wire selected;
  wire sclk_rise;
  wire sclk_fall;

  // shift path and bit counting
  reg [15:0] shreg;
  reg [2:0] bit_mod8;
  reg any_bits;
  reg [15:0] next_shreg;
  reg [2:0] next_bit_mod8;
  reg next_any_bits;
  reg next_so;
  reg next_so_oe;

  // pending response description
  reg [1:0] resp_kind;
  reg [2:0] resp_addr;
  reg [1:0] next_resp_kind;
  reg [2:0] next_resp_addr;

  // sticky error flags
  reg frame_err;
  reg cmd_err;
  reg next_frame_err;
  reg next_cmd_err;

  // register writes
  reg [11:0] next_cfg0;
  reg [11:0] next_cfg1;
  reg [11:0] next_cfg2;
  reg [11:0] next_cfg3;

  // decode of the received frame
  wire frame_ok;
  wire rx_wr;
  wire [2:0] rx_addr;
  wire [11:0] rx_data;

  // response assembly
  reg [11:0] resp_data;
  wire [15:0] resp_word;

  // the core clock must run well above the link clock for edge finding
  sync_two_ff #(
    .RESET_VAL(1'b1)
  ) u_sync_cs (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async(i_cs_n),
    .o_sync(cs_n_s)
  );

  sync_two_ff #(
    .RESET_VAL(1'b0)
  ) u_sync_sclk (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async(i_sclk),
    .o_sync(sclk_s)
  );

  // same delay as the clock, so data lines up with its edge
  sync_two_ff #(
    .RESET_VAL(1'b0)
  ) u_sync_si (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async(i_si),
    .o_sync(si_s)
  );

  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end
    else
    begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  assign cs_fall = cs_n_d & ~cs_n_s;
  assign cs_rise = ~cs_n_d & cs_n_s;
  // clock edges only count inside a frame
  assign selected = ~cs_n_s & ~cs_n_d; // R01
  // a clock held low around select edges never fakes an edge here
  assign sclk_rise = selected & sclk_s & ~sclk_d; // R06
  assign sclk_fall = selected & ~sclk_s & sclk_d; // R05

  // last sixteen bits received are this device's frame
  assign rx_wr = shreg[`WR_BIT]; // R11
  assign rx_addr = shreg[`ADDR_MSB:`ADDR_LSB]; // R11
  assign rx_data = shreg[`DATA_MSB:`DATA_LSB]; // R11
  assign frame_ok = any_bits & (bit_mod8 == 3'h0); // R04

  // data of the pending response, taken live at frame start
  always @*
  begin
    resp_data = 12'h000;
    case (resp_kind)
      `RESP_REG:
      begin
        case (resp_addr)
          `ADDR_CFG0: resp_data = o_cfg0;
          `ADDR_CFG1: resp_data = o_cfg1;
          `ADDR_CFG2: resp_data = o_cfg2;
          `ADDR_CFG3: resp_data = o_cfg3;
          default: resp_data = 12'h000;
        endcase
      end
      `RESP_SDIAG: resp_data = i_diag;
      `RESP_FEEDBACK: resp_data = {10'h000, frame_err, cmd_err};
      default: resp_data = 12'h000;
    endcase
  end

  response_word u_resp (
    .i_addr(resp_addr),
    .i_data(resp_data),
    .o_word(resp_word)
  );

  // shift path, counter and output pin
  always @*
  begin
    next_shreg = shreg;
    next_bit_mod8 = bit_mod8;
    next_any_bits = any_bits;
    next_so = o_so;
    next_so_oe = ~cs_n_s; // R02
    if (cs_fall)
    begin
      next_shreg = resp_word; // R03
      next_so = resp_word[`FRAME_MSB]; // R08
      next_bit_mod8 = 3'h0;
      next_any_bits = 1'b0;
    end
    else if (sclk_fall)
    begin
      // one register does both directions: a chained bit leaves
      // sixteen clocks after it arrived
      next_shreg = {shreg[14:0], si_s}; // R09
      next_bit_mod8 = (bit_mod8 + 3'h1) & `BYTE_BITS_MASK; // R04
      next_any_bits = 1'b1;
    end
    else if (sclk_rise)
    begin
      next_so = shreg[`FRAME_MSB]; // R07
    end
  end

  // frame decode at the rising select edge
  always @*
  begin
    next_cfg0 = o_cfg0;
    next_cfg1 = o_cfg1;
    next_cfg2 = o_cfg2;
    next_cfg3 = o_cfg3;
    next_resp_kind = resp_kind;
    next_resp_addr = resp_addr;
    next_frame_err = frame_err;
    next_cmd_err = cmd_err;
    // flags are read out, then cleared, as the feedback frame starts
    if (cs_fall && resp_kind == `RESP_FEEDBACK)
    begin
      next_frame_err = 1'b0;
      next_cmd_err = 1'b0;
    end
    if (cs_rise)
    begin
      if (!frame_ok)
      begin
        // frame dropped, previous response stays pending
        next_frame_err = 1'b1; // R20
      end
      else if (rx_addr == `ADDR_CMD)
      begin
        if (!rx_wr && rx_data == `SHORT_DIAG_STATUS_CMD)
        begin
          next_resp_kind = `RESP_SDIAG;
          next_resp_addr = `ADDR_CMD;
        end
        else if (!rx_wr && rx_data == `STATUS_FEEDBACK_CMD)
        begin
          next_resp_kind = `RESP_FEEDBACK;
          next_resp_addr = `ADDR_CMD;
        end
        else
        begin
          next_cmd_err = 1'b1; // R22
        end
      end
      else if (rx_addr == `ADDR_DIAG)
      begin
        if (rx_wr)
        begin
          next_cmd_err = 1'b1; // R22
        end
        else
        begin
          next_resp_kind = `RESP_SDIAG; // R14
          next_resp_addr = `ADDR_DIAG;
        end
      end
      else if (rx_addr >= `ADDR_CFG0 && rx_addr <= `ADDR_CFG3)
      begin
        if (rx_wr)
        begin
          case (rx_addr)
            `ADDR_CFG0: next_cfg0 = rx_data; // R12
            `ADDR_CFG1: next_cfg1 = rx_data; // R12
            `ADDR_CFG2: next_cfg2 = rx_data; // R12
            `ADDR_CFG3: next_cfg3 = rx_data; // R12
            default: next_cfg0 = o_cfg0;
          endcase
        end
        // write or read: next frame shows this register
        next_resp_kind = `RESP_REG; // R13
        next_resp_addr = rx_addr; // R14
      end
      else
      begin
        next_cmd_err = 1'b1; // R22
      end
    end
  end

  // link side state
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      shreg <= 16'h0000;
      bit_mod8 <= 3'h0;
      any_bits <= 1'b0;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end
    else
    begin
      // runs on the core clock in place of the internal oscillator
      shreg <= next_shreg; // R19
      bit_mod8 <= next_bit_mod8;
      any_bits <= next_any_bits;
      o_so <= next_so;
      o_so_oe <= next_so_oe;
    end
  end

  // only the reset pin clears state; enable has no say here
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_cfg0 <= `CFG_RESET; // R21
      o_cfg1 <= `CFG_RESET; // R21
      o_cfg2 <= `CFG_RESET; // R21
      o_cfg3 <= `CFG_RESET; // R21
    end
    else
    begin
      o_cfg0 <= next_cfg0;
      o_cfg1 <= next_cfg1;
      o_cfg2 <= next_cfg2;
      o_cfg3 <= next_cfg3;
    end
  end

  // pending response and error flags
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      resp_kind <= `RESP_SDIAG; // R18
      resp_addr <= `RESP_ADDR_RESET; // R18
      frame_err <= 1'b0;
      cmd_err <= 1'b0;
      o_comm_err <= 1'b0;
    end
    else
    begin
      // a read frame also executes its own command while sending data
      resp_kind <= next_resp_kind; // R15
      resp_addr <= next_resp_addr;
      frame_err <= next_frame_err;
      cmd_err <= next_cmd_err;
      o_comm_err <= next_frame_err | next_cmd_err;
    end
  end

endmodule

/* verif/spi_slave_command_port_props.sv */
`timescale 1ns/100ps
module spi_slave_command_port_props (
  // clock, reset and link
  input wire i_mclk, i_arst_n, i_cs_n, i_sclk, i_si, o_so, o_so_oe,
  // levels
  input wire [11:0] i_diag, o_cfg0, o_cfg1, o_cfg2, o_cfg3,
  input wire o_comm_err
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  sequence cs_fall;
    $fell(i_cs_n);
  endsequence
  sequence drive_on;
    ##[2:4] o_so_oe;
  endsequence
  sequence cs_rise;
    $rose(i_cs_n);
  endsequence
  sequence drive_off;
    ##[2:4] !o_so_oe;
  endsequence
  so_tristate_a: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("serial output driven while deselected");
  so_enable_a: assert property (cs_fall |-> drive_on)
    else $error("serial output not enabled after select");
  so_release_a: assert property (cs_rise |-> drive_off)
    else $error("serial output not released after deselect");
  so_edge_a: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so)
    |-> $past(i_sclk, 3) || $past(i_sclk, 4))
    else $error("serial output changed without a rising clock");
  cfg_hold_a: assert property (!i_cs_n [*6]
    |-> $stable({o_cfg0, o_cfg1, o_cfg2, o_cfg3}))
    else $error("register changed inside a frame");
  cfg_update_a: assert property ($changed({o_cfg0, o_cfg1, o_cfg2,
    o_cfg3}) |-> i_cs_n && $past(i_cs_n, 2))
    else $error("register changed away from frame end");
  err_set_a: assert property ($rose(o_comm_err)
    |-> i_cs_n && $past(i_cs_n, 2))
    else $error("error flag raised away from frame end");
  reset_vals_a: assert property (@(negedge i_mclk) disable iff (1'b0)
    !i_arst_n |-> !o_so_oe && !o_comm_err && o_cfg0 == 12'h000
    && o_cfg1 == 12'h000 && o_cfg2 == 12'h000 && o_cfg3 == 12'h000)
    else $error("reset values wrong");
endmodule

bind spi_slave_command_port spi_slave_command_port_props i_props (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
  .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .i_diag(i_diag),
  .o_cfg0(o_cfg0), .o_cfg1(o_cfg1), .o_cfg2(o_cfg2), .o_cfg3(o_cfg3),
  .o_comm_err(o_comm_err));

/* verif/spi_master_model.sv */
`timescale 1ns/100ps
module spi_master_model (
  // clock used only for pacing
  input wire i_mclk,
  // serial link
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si,
  input wire i_so
);
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  task automatic half_bit();
    repeat (8) @(negedge i_mclk);
  endtask
  // shifts the low n bits of tx, msb first; so is taken at sclk fall
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    repeat (3) half_bit();
    for (int i = n - 1; i >= 0; i--)
    begin
      repeat (4) @(negedge i_mclk);
      o_si = tx[i];
      repeat (4) @(negedge i_mclk);
      o_sclk = 1'b1;
      half_bit();
      rx = {rx[30:0], i_so};
      o_sclk = 1'b0;
    end
    repeat (3) half_bit();
    o_si = 1'b0;
    o_cs_n = 1'b1;
    repeat (4) half_bit();
  endtask
endmodule

/* verif/spi_slave_command_port_bench.sv */
`timescale 1ns/100ps
module spi_slave_command_port_bench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] diag = 12'hA5C;
  wire cs_n, sclk, si, so, so_oe, so_line, comm_err;
  wire [11:0] cfg0, cfg1, cfg2, cfg3;
  logic [31:0] rx;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  // released output floats, so a late read never matches a bit
  assign so_line = so_oe ? so : 1'bz;
  always #5 mclk = ~mclk;
  spi_slave_command_port i_spi_slave_command_port (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_diag(diag),
    .o_cfg0(cfg0), .o_cfg1(cfg1), .o_cfg2(cfg2), .o_cfg3(cfg3),
    .o_comm_err(comm_err));
  spi_master_model i_spi_master_model (
    .i_mclk(mclk), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si),
    .i_so(so_line));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] resp(input logic [2:0] a,
                                       input logic [11:0] d);
    return {^{a, d}, a, d};
  endfunction
  task automatic frame(input logic [15:0] tx);
    i_spi_master_model.xfer({16'h0000, tx}, 16, rx);
  endtask
  task automatic t_read_write();
    frame(16'h9123);
    check(rx, resp(3'h7, 12'hA5C));
    check(cfg0, 12'h123);
    diag = 12'h3B1;
    frame(16'h2000);
    check(rx, resp(3'h1, 12'h123));
    frame(16'h0000);
    check(rx, resp(3'h2, 12'h000));
    frame(16'h73C5);
    check(rx, resp(3'h0, 12'h3B1));
    frame(16'h0000);
    check(rx, resp(3'h7, 12'h3B1));
  endtask
  task automatic t_errors();
    i_spi_master_model.xfer(32'h0000_9FFF, 20, rx);
    check(cfg0, 12'h123);
    check(comm_err, 1'b1);
    frame(16'h5000);
    check(rx, resp(3'h0, 12'h3B1));
    frame(16'h8123);
    check(rx, resp(3'h0, 12'h3B1));
    frame(16'h73CA);
    check(rx, resp(3'h0, 12'h3B1));
    frame(16'h0000);
    check(rx, resp(3'h7, 12'h003));
    check(comm_err, 1'b0);
  endtask
  task automatic t_daisy();
    i_spi_master_model.xfer(32'hC0DE_A456, 32, rx);
    check(rx[31:16], resp(3'h0, 12'h3B1));
    check(rx[15:0], 16'hC0DE);
    check(cfg1, 12'h456);
    frame(16'h0000);
    check(rx, resp(3'h2, 12'h456));
  endtask
  task automatic t_upper_regs();
    frame(16'hB789);
    check(cfg2, 12'h789);
    check(so_oe, 1'b0);
    frame(16'hCABC);
    check(rx, resp(3'h3, 12'h789));
    check(cfg3, 12'hABC);
    frame(16'h4000);
    check(rx, resp(3'h4, 12'hABC));
  endtask
  task automatic t_reset();
    @(negedge mclk);
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    check({cfg0, cfg1}, 24'h000000);
    check({cfg2, cfg3}, 24'h000000);
    check({comm_err, so_oe}, 2'h0);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    frame(16'h0000);
    check(rx, resp(3'h7, 12'h3B1));
  endtask
  task automatic finish_test();
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_read_write();
    t_errors();
    t_daisy();
    t_upper_regs();
    t_reset();
    finish_test();
  end
  // about 6000 cycles expected; a hang meets the ceiling and fails
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
endmodule
